// ==== flash_security_vector_protection_bench.sv ====
// Purpose: self-checking bench for the security vector decode
// Assumes: vectors fetched after every reset from the flash model
// Notes:   one row per protection case, each with its own reset
`timescale 1ns/100ps
module flash_security_vector_protection_bench
    import fsvp_pkg::*;
;
    typedef struct packed {
        logic [31:0] mv;
        logic [31:0] lv;
        logic [2:0]  bm;
        logic        wr;
        logic [23:0] addr;
        logic        gr;
        logic        rb;
        logic        wb;
        logic [19:0] wp;
    } fsvp_row_t;
    // vector words keep the holding sector mask cleared
    fsvp_row_t rows [10] = '{
        '{32'h0000_00EF, 32'h0000_0000, 3'b111, 1'b1, 24'h14_8000, 1'b1, 1'b0, 1'b0, 20'h0_0000},
        '{32'h0002_00EF, 32'h0000_0FFE, 3'b111, 1'b1, 24'h14_8000, 1'b0, 1'b0, 1'b1, 20'h0_0110},
        '{32'h0002_00EF, 32'h0000_0FFE, 3'b111, 1'b1, 24'h04_0000, 1'b0, 1'b0, 1'b1, 20'h0_0110},
        '{32'h0002_00EF, 32'h0000_0FFE, 3'b111, 1'b1, 24'h14_8004, 1'b1, 1'b0, 1'b1, 20'h0_0110},
        '{32'h0002_00EF, 32'h0000_07FF, 3'b000, 1'b1, 24'h0E_0004, 1'b0, 1'b0, 1'b1, 20'h8_0010},
        '{32'h0006_00EF, 32'h0000_07FF, 3'b000, 1'b1, 24'h0E_0004, 1'b1, 1'b0, 1'b0, 20'h8_0010},
        '{32'h0006_00EF, 32'h0000_07FF, 3'b111, 1'b1, 24'h0E_0004, 1'b0, 1'b0, 1'b1, 20'h8_0010},
        '{32'h0001_00EF, 32'h0000_0FFF, 3'b111, 1'b0, 24'h14_8000, 1'b0, 1'b1, 1'b0, 20'h0_0000},
        '{32'h0001_00EF, 32'h0000_0FFF, 3'b000, 1'b0, 24'h14_8000, 1'b1, 1'b0, 1'b0, 20'h0_0000},
        '{32'h0003_00EE, 32'h0000_0FFF, 3'b110, 1'b1, 24'h14_0000, 1'b0, 1'b1, 1'b1, 20'h0_0011}};
    logic        clk = 1'b0, rst_n = 1'b0, acc_req = 1'b0, acc_write = 1'b0;
    logic [2:0]  boot_mode = 3'b111;
    logic [3:0]  lat = 4'h1;
    logic [23:0] acc_addr = 24'h00_0000;
    logic [31:0] rdata_array = 32'h0000_0000, mode_vec = 32'h0000_0000, large_vec = 32'h0000_0000;
    logic        fl_rd_req, fl_rd_valid, acc_grant, acc_denied, array_wr_en, fetch_done, prog_ok, read_blk, write_blk;
    logic [23:0] fl_rd_addr;
    logic [31:0] fl_rd_data, acc_rdata;
    logic [19:0] sector_wp;
    logic [19:0] sector_wp_small;
    int          num_errors = 0, compares = 0;
    fsvp_top fsvp_top_inst (.CLK(clk), .RST_N(rst_n), .BOOT_MODE_PINS(boot_mode), .FL_RD_REQ(fl_rd_req),
        .FL_RD_ADDR(fl_rd_addr), .FL_RD_DATA(fl_rd_data), .FL_RD_VALID(fl_rd_valid), .ACC_REQ(acc_req),
        .ACC_WRITE(acc_write), .ACC_ADDR(acc_addr), .ACC_RDATA_ARRAY(rdata_array), .ACC_GRANT(acc_grant),
        .ACC_DENIED(acc_denied), .ACC_RDATA(acc_rdata), .ARRAY_WR_EN(array_wr_en), .FETCH_DONE(fetch_done),
        .PROG_ACCESS_OK(prog_ok), .READ_BLOCKED(read_blk), .WRITE_BLOCKED(write_blk), .SECTOR_WP(sector_wp));
    fsvp_flash_model fsvp_flash_model_inst (.CLK(clk), .RST_N(rst_n), .FL_RD_REQ(fl_rd_req),
        .FL_RD_ADDR(fl_rd_addr), .FL_RD_DATA(fl_rd_data), .FL_RD_VALID(fl_rd_valid),
        .MODE_WORD(mode_vec), .LARGE_WORD(large_vec), .LATENCY(lat));
    // reduced variant shares the fetch answers of the full one
    fsvp_top #(.SMALL_VARIANT(1'b1)) fsvp_top_small_inst (.CLK(clk), .RST_N(rst_n), .BOOT_MODE_PINS(boot_mode),
        .FL_RD_REQ(), .FL_RD_ADDR(), .FL_RD_DATA(fl_rd_data), .FL_RD_VALID(fl_rd_valid), .ACC_REQ(acc_req),
        .ACC_WRITE(acc_write), .ACC_ADDR(acc_addr), .ACC_RDATA_ARRAY(rdata_array), .ACC_GRANT(), .ACC_DENIED(),
        .ACC_RDATA(), .ARRAY_WR_EN(), .FETCH_DONE(), .PROG_ACCESS_OK(), .READ_BLOCKED(), .WRITE_BLOCKED(),
        .SECTOR_WP(sector_wp_small));
    initial begin
        forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
    end
    task automatic give_verdict;
        if (num_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // mode pins change on the same edge that applies reset
    task automatic restart(input logic [2:0] bm);
        @(posedge clk);
        boot_mode <= bm;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic wait_fetch;
        int n;
        n = 0;
        while (fetch_done !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("fetch_done", 32'h1, fetch_done);
    endtask
    task automatic access(input logic wr, input logic [23:0] addr);
        @(posedge clk);
        acc_req <= 1'b1;
        acc_write <= wr;
        acc_addr <= addr;
        rdata_array <= {8'h5A, addr};
        @(posedge clk);
        acc_req <= 1'b0;
        #1;
    endtask
    initial begin
        mode_vec = 32'h0000_00EF;
        large_vec = 32'h0000_0FFF;
        restart(3'b111);
        #1;
        chk("prog_ok", 32'h0, prog_ok);
        chk("sector_wp", 32'h000F_FFFF, sector_wp);
        chk("sector_wp_small", 32'h000F_FFFF, sector_wp_small);
        chk("reset_read_blk", 32'h1, read_blk);
        chk("reset_write_blk", 32'h1, write_blk);
        access(1'b1, 24'h14_8004);
        chk("early_denied", 32'h1, acc_denied);
        chk("early_wr_en", 32'h0, array_wr_en);
        wait_fetch();
        foreach (rows[i]) begin
            mode_vec = rows[i].mv;
            large_vec = rows[i].lv;
            lat = 4'(1 + i % 3);
            restart(rows[i].bm);
            wait_fetch();
            access(rows[i].wr, rows[i].addr);
            chk("grant", 32'(rows[i].gr), acc_grant);
            chk("denied", 32'(!rows[i].gr), acc_denied);
            chk("wr_en", 32'(rows[i].gr & rows[i].wr), array_wr_en);
            chk("rdata", (rows[i].gr & !rows[i].wr) ? {8'h5A, rows[i].addr} : 32'h0, acc_rdata);
            chk("read_blk", 32'(rows[i].rb), read_blk);
            chk("write_blk", 32'(rows[i].wb), write_blk);
            chk("sector_wp", 32'(rows[i].wp), sector_wp);
            chk("sector_wp_small", 32'(rows[i].wp & 20'hF_C0F0), sector_wp_small);
            chk("prog_ok", 32'(rows[i].bm == 3'b111), prog_ok);
        end
        @(posedge clk);
        acc_req <= 1'b1;
        acc_write <= 1'b1;
        acc_addr <= 24'h14_0000;
        @(posedge clk);
        acc_addr <= 24'h14_0004;
        #1;
        chk("b2b_denied", 32'h1, acc_denied);
        @(posedge clk);
        acc_req <= 1'b0;
        #1;
        chk("b2b_wr_en", 32'h1, array_wr_en);
        give_verdict();
    end
    initial begin
        #(4000 * CLK_PERIOD_NS);
        num_errors++;
        give_verdict();
    end
endmodule

// ==== fsvp_flash_model.sv ====
// Purpose: flash array answering the vector fetch reads
// Assumes: one word per request, answer after LATENCY edges
// Notes:   idle data bus toggles to its own inverse every cycle
`timescale 1ns/100ps
module fsvp_flash_model
    import fsvp_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // fetch port
    input  wire logic        FL_RD_REQ,
    input  wire logic [23:0] FL_RD_ADDR,
    output logic      [31:0] FL_RD_DATA,
    output logic             FL_RD_VALID,
    // stored vectors and answer delay
    input  wire logic [31:0] MODE_WORD,
    input  wire logic [31:0] LARGE_WORD,
    input  wire logic [3:0]  LATENCY
);
    logic [23:0] addr_reg;
    logic [3:0]  wait_reg;
    initial FL_RD_DATA = 32'h0000_0000;
    always @(posedge CLK) begin
        FL_RD_VALID <= 1'b0;
        FL_RD_DATA  <= ~FL_RD_DATA;
        if (!RST_N) begin
            wait_reg <= 4'h0;
        end else if (FL_RD_REQ) begin
            addr_reg <= FL_RD_ADDR;
            wait_reg <= LATENCY;
        end else if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
            if (wait_reg == 4'h1) begin
                FL_RD_VALID <= 1'b1;
                // unknown address answers garbage
                FL_RD_DATA  <= (addr_reg == MODE_VEC_ADDR) ? MODE_WORD :
                               (addr_reg == LARGE_VEC_ADDR) ? LARGE_WORD : ~FL_RD_DATA;
            end
        end
    end
endmodule

// ==== fsvp_pkg.sv ====
// Purpose: constants for the flash security vector protection block
// Assumes: 40 MHz core clock, 32-bit flash read port
// Notes:   vector addresses are flash byte addresses
package fsvp_pkg;
    localparam int          CLK_PERIOD_NS     = 25;
    // flash addresses of the two fetched vectors and their interleaved guards
    localparam logic [23:0] MODE_VEC_ADDR     = 24'h14_8000;
    localparam logic [23:0] GUARD_A_ADDR      = 24'h14_8004;
    localparam logic [23:0] LARGE_VEC_ADDR    = 24'h14_8008;
    localparam logic [23:0] GUARD_B_ADDR      = 24'h14_800C;
    // field positions in the mode vector, sector counts and large base
    localparam int          RD_PROT_BIT       = 16;
    localparam int          WR_PROT_BIT       = 17;
    localparam int          WR_LEVEL_BIT      = 18;
    localparam int          SMALL_SECTORS     = 8;
    localparam int          LARGE_SECTORS     = 12;
    localparam int          NUM_SECTORS       = 20;
    localparam int          LARGE_BASE        = 8;
    // first populated mask bit on the smaller variant
    localparam int          SMALL_FIRST_REDUCED = 4;
    localparam int          LARGE_FIRST_REDUCED = 6;
    localparam logic [2:0]  MODE_INTERNAL_VECTOR_BOOT       = 3'b000;
    localparam logic [2:0]  MODE_PARALLEL     = 3'b111;
    // fail-safe vector value before the fetch completes
    localparam logic [31:0] VEC_SAFE          = 32'h0000_0000;
endpackage

// ==== fsvp_sector_decode.sv ====
// Purpose: map a flash byte address to a sector index
// Assumes: sector layout with 8 KB sectors at 0x14_0000 and 64 KB from 0x04_0000
// Notes:   combinational; out-of-range addresses report no sector
`timescale 1ns/100ps
module fsvp_sector_decode
    import fsvp_pkg::*;
(
    input  wire logic [23:0] addr,
    output logic      [4:0]  sector,
    output logic             hit
);
    localparam logic [7:0] SMALL_BANK  = 8'h14;
    localparam logic [7:0] LARGE_LO    = 8'h04;
    localparam logic [7:0] LARGE_HI    = 8'h0F;
    localparam logic [2:0] LARGE_PAIR0 = 3'h2;

    wire        small_area = (addr[23:16] == SMALL_BANK);
    wire        large_area = (addr[23:16] >= LARGE_LO) && (addr[23:16] <= LARGE_HI);
    // 8 KB sectors interleave on addr[2]; pairs every 16 KB
    wire [4:0]  small_idx  = {2'b00, addr[15:14], addr[2]};
    // 64 KB sectors interleave on addr[2]; pairs every 128 KB
    wire [2:0]  pair_off   = addr[19:17] - LARGE_PAIR0;
    wire [4:0]  large_idx  = 5'(LARGE_BASE) + {1'b0, pair_off, addr[2]};
    assign sector = small_area ? small_idx : large_idx;
    assign hit    = small_area || large_area;
endmodule

// ==== fsvp_top.sv ====
// Purpose: fetch security vectors and gate flash access by decoded protection
// Assumes: flash answers a read with FL_RD_VALID any number of cycles after FL_RD_REQ
// Notes:   until the fetch finishes everything reads as protected
// Operation
// - fetch vectors after reset; programming access only once fetch is done
// - mode vector at 0x14_8000, large vector at 0x14_8008, guards interleaved
// - bits 18,17,16 are level, write enable, read enable; upper bits zero
// - read enable blocks reads in all boot modes but internal-vector mode
// - write enable with level zero protects writes in every mode
// - write enable with level one exempts internal-vector mode
// - sector masks apply only while write enable bit is set
// - mode vector bits 0..7 protect 8 KB sectors 0..7 when zero, bits 4..7 only on the smaller variant
// - large vector bits 0..11 protect 64 KB sectors 8..19 when zero, bits 6..11 only on the smaller variant
`timescale 1ns/100ps
module fsvp_top
    import fsvp_pkg::*;
#(
    parameter bit SMALL_VARIANT = 1'b0
)(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // boot mode
    input  wire logic [2:0]  BOOT_MODE_PINS,
    // vector fetch port to flash
    output logic             FL_RD_REQ,
    output logic      [23:0] FL_RD_ADDR,
    input  wire logic [31:0] FL_RD_DATA,
    input  wire logic        FL_RD_VALID,
    // access requests from CPU or programmer
    input  wire logic        ACC_REQ,
    input  wire logic        ACC_WRITE,
    input  wire logic [23:0] ACC_ADDR,
    input  wire logic [31:0] ACC_RDATA_ARRAY,
    // gated outputs
    output logic             ACC_GRANT,
    output logic             ACC_DENIED,
    output logic      [31:0] ACC_RDATA,
    output logic             ARRAY_WR_EN,
    // decoded status
    output logic             FETCH_DONE,
    output logic             PROG_ACCESS_OK,
    output logic             READ_BLOCKED,
    output logic             WRITE_BLOCKED,
    output logic      [19:0] SECTOR_WP
);
    typedef enum logic [2:0] {FSVP_ST_MODE, FSVP_ST_WAIT_MODE, FSVP_ST_LARGE,
                              FSVP_ST_WAIT_LARGE, FSVP_ST_DONE} fsvp_state_t;

    fsvp_state_t state_reg, state_next;
    logic [31:0] mode_vec_reg, mode_vec_next;
    logic [31:0] large_vec_reg, large_vec_next;

    function automatic logic [31:0] fsvp_mask_pop(input logic [31:0] v, input int first);
        logic [31:0] m;
        m = v;
        for (int i = 0; i < 32; i++) begin
            if (i < first) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // protection decode and access gating
    wire        fetch_done   = (state_reg == FSVP_ST_DONE);
    wire        internal_vector_boot       = (BOOT_MODE_PINS == MODE_INTERNAL_VECTOR_BOOT);
    wire        rd_en_bit    = mode_vec_reg[RD_PROT_BIT];
    wire        wr_en_bit    = mode_vec_reg[WR_PROT_BIT];
    wire        wr_lvl_bit   = mode_vec_reg[WR_LEVEL_BIT];
    wire        rd_blocked   = !fetch_done || (rd_en_bit && !internal_vector_boot);
    wire        wr_mode      = wr_en_bit && !(wr_lvl_bit && internal_vector_boot);
    wire [31:0] small_eff    = SMALL_VARIANT ? fsvp_mask_pop(mode_vec_reg, SMALL_FIRST_REDUCED)
                                             : mode_vec_reg;
    wire [31:0] large_eff    = SMALL_VARIANT ? fsvp_mask_pop(large_vec_reg, LARGE_FIRST_REDUCED)
                                             : large_vec_reg;
    wire [19:0] mask_wp      = ~{large_eff[LARGE_SECTORS-1:0], small_eff[SMALL_SECTORS-1:0]};
    wire [19:0] sector_wp    = fetch_done ? (wr_en_bit ? mask_wp : 20'h0_0000) : 20'hF_FFFF;
    wire        wr_blocked   = !fetch_done || wr_mode;
    wire [4:0]  acc_sector;
    wire        acc_hit;
    wire        sec_prot     = acc_hit && (acc_sector < 5'(NUM_SECTORS)) && sector_wp[acc_sector];
    wire        wr_ok        = ACC_REQ && ACC_WRITE && fetch_done && !(wr_mode && sec_prot);
    wire        rd_ok        = ACC_REQ && !ACC_WRITE && !rd_blocked;
    wire        prog_mode    = (BOOT_MODE_PINS == MODE_PARALLEL);

    fsvp_sector_decode u_decode (
        .addr   (ACC_ADDR),
        .sector (acc_sector),
        .hit    (acc_hit)
    );

    // vector fetch sequencer, one word per request and wait pair
    always_comb begin
        state_next     = state_reg;
        mode_vec_next  = mode_vec_reg;
        large_vec_next = large_vec_reg;
        case (state_reg)
            FSVP_ST_MODE:       state_next = FSVP_ST_WAIT_MODE;
            FSVP_ST_WAIT_MODE: begin
                if (FL_RD_VALID) begin
                    mode_vec_next = FL_RD_DATA;
                    state_next    = FSVP_ST_LARGE;
                end
            end
            FSVP_ST_LARGE:      state_next = FSVP_ST_WAIT_LARGE;
            FSVP_ST_WAIT_LARGE: begin
                if (FL_RD_VALID) begin
                    large_vec_next = FL_RD_DATA;
                    state_next     = FSVP_ST_DONE;
                end
            end
            FSVP_ST_DONE:       state_next = FSVP_ST_DONE;
            default:            state_next = FSVP_ST_MODE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_reg     <= FSVP_ST_MODE;
            mode_vec_reg  <= VEC_SAFE;
            large_vec_reg <= VEC_SAFE;
        end else begin
            state_reg     <= state_next;
            mode_vec_reg  <= mode_vec_next;
            large_vec_reg <= large_vec_next;
        end
    end

    // fetch port and gated access outputs
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            FL_RD_REQ      <= 1'b0;
            FL_RD_ADDR     <= MODE_VEC_ADDR;
            ACC_GRANT      <= 1'b0;
            ACC_DENIED     <= 1'b0;
            ACC_RDATA      <= 32'h0000_0000;
            ARRAY_WR_EN    <= 1'b0;
            FETCH_DONE     <= 1'b0;
            PROG_ACCESS_OK <= 1'b0;
            READ_BLOCKED   <= 1'b1;
            WRITE_BLOCKED  <= 1'b1;
            SECTOR_WP      <= 20'hF_FFFF;
        end else begin
            FL_RD_REQ      <= (state_next == FSVP_ST_WAIT_MODE && state_reg == FSVP_ST_MODE) ||
                              (state_next == FSVP_ST_WAIT_LARGE && state_reg == FSVP_ST_LARGE);
            FL_RD_ADDR     <= (state_reg == FSVP_ST_MODE) ? MODE_VEC_ADDR : LARGE_VEC_ADDR;
            ACC_GRANT      <= wr_ok || rd_ok;
            ACC_DENIED     <= ACC_REQ && !(wr_ok || rd_ok);
            ACC_RDATA      <= rd_ok ? ACC_RDATA_ARRAY : 32'h0000_0000;
            ARRAY_WR_EN    <= wr_ok;
            FETCH_DONE     <= fetch_done;
            PROG_ACCESS_OK <= fetch_done && prog_mode;
            READ_BLOCKED   <= rd_blocked;
            WRITE_BLOCKED  <= wr_blocked;
            SECTOR_WP      <= sector_wp;
        end
    end

    sequence s_fetch_first;
        FL_RD_REQ && FL_RD_ADDR == MODE_VEC_ADDR;
    endsequence
    sequence s_fetch_second;
        FL_RD_REQ && FL_RD_ADDR == LARGE_VEC_ADDR;
    endsequence
    sequence s_no_answer;
        !ACC_GRANT && !ACC_DENIED && !ARRAY_WR_EN;
    endsequence

    a_fetch_addr_first: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(RST_N) |-> ##[1:3] s_fetch_first)
        else $error("first fetch not at mode vector address");
    a_prog_after_fetch: assert property (@(posedge CLK) disable iff (!RST_N)
        PROG_ACCESS_OK |-> $past(fetch_done))
        else $error("programming access before fetch done");
    a_read_blocked: assert property (@(posedge CLK) disable iff (!RST_N)
        (fetch_done && rd_en_bit && !internal_vector_boot && ACC_REQ && !ACC_WRITE) |=> ACC_DENIED && ACC_RDATA == 32'h0000_0000)
        else $error("protected read not blocked");
    a_write_all_modes: assert property (@(posedge CLK) disable iff (!RST_N)
        (fetch_done && wr_en_bit && !wr_lvl_bit && ACC_REQ && ACC_WRITE && sec_prot) |=> !ARRAY_WR_EN && ACC_DENIED)
        else $error("level zero write protection bypassed");
    a_write_internal_vector_boot_exempt: assert property (@(posedge CLK) disable iff (!RST_N)
        (fetch_done && wr_lvl_bit && internal_vector_boot && ACC_REQ && ACC_WRITE) |=> ARRAY_WR_EN)
        else $error("internal-vector mode not exempt at level one");
    a_masks_gated: assert property (@(posedge CLK) disable iff (!RST_N)
        (FETCH_DONE && !$past(wr_en_bit)) |-> SECTOR_WP == 20'h0_0000)
        else $error("sector masks applied without write enable");
    a_small_map: assert property (@(posedge CLK) disable iff (!RST_N)
        (fetch_done && wr_en_bit && !SMALL_VARIANT) |=> SECTOR_WP[7:0] == ~$past(mode_vec_reg[7:0]))
        else $error("small sector mask mismatch");
    a_large_map: assert property (@(posedge CLK) disable iff (!RST_N)
        (fetch_done && wr_en_bit && !SMALL_VARIANT) |=> SECTOR_WP[19:8] == ~$past(large_vec_reg[11:0]))
        else $error("large sector mask mismatch");
    a_small_variant: assert property (@(posedge CLK) disable iff (!RST_N)
        (fetch_done && SMALL_VARIANT) |=> SECTOR_WP[3:0] == 4'h0 && SECTOR_WP[13:8] == 6'h00)
        else $error("unpopulated sector marked protected");

    // fetch order, access answers and fail-safe state
    a_fetch_second: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_reg == FSVP_ST_WAIT_MODE && FL_RD_VALID) |-> ##2 s_fetch_second)
        else $error("second fetch not at large vector address");
    a_no_early_grant: assert property (@(posedge CLK) disable iff (!RST_N)
        !fetch_done |=> !ACC_GRANT && !ARRAY_WR_EN && !PROG_ACCESS_OK)
        else $error("access granted before fetch done");
    a_safe_until_fetch: assert property (@(posedge CLK) disable iff (!RST_N)
        !FETCH_DONE |-> SECTOR_WP == 20'hF_FFFF && READ_BLOCKED && WRITE_BLOCKED)
        else $error("protection open before fetch done");
    a_answer_once: assert property (@(posedge CLK) disable iff (!RST_N)
        ACC_REQ |=> ACC_GRANT != ACC_DENIED)
        else $error("request not answered exactly once");
    a_idle_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
        !ACC_REQ |=> s_no_answer)
        else $error("answer without request");
    a_denied_clean: assert property (@(posedge CLK) disable iff (!RST_N)
        ACC_DENIED |-> !ARRAY_WR_EN && ACC_RDATA == 32'h0000_0000)
        else $error("denied access passed data or write");
endmodule
